//--- flash_wait_state_access_ctrl.sv
/*
 * Flash access controller front end: an AHB-Lite slave that serves reads
 * and writes to the flash array with a programmable access delay, a keyed
 * update path for that delay, and per-segment erase-before-write tracking.
 * Assumes the flash macro, the key/delay write strobes and the erase
 * request all run on ref_clk_i; the bus matrix arbitrates between the
 * processor core and the debug port in front of this slave.
 */
// Summary of operation
// - Access delay per flash access is programmable from zero to three.
// - Reset leaves the access delay at three.
// - Delay stretches flash accesses so flash never runs above 25 MHz.
// - The access delay may be updated at any time during operation.
// - A delay write is taken only after the unlock key 0x12345678.
// - Once accepted, every later flash read uses the new delay.
// - The flash array starts at bus address zero.
// - The array is 32 KB as thirty-two 1 KB segments.
// - An erase clears exactly one 1 KB segment.
// - Bus requests from core and debug port are served over AHB.
// - A direct write stalls the bus transfer until programming completes.
`timescale 1ns/10ps
`default_nettype none
module flash_wait_state_access_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int unsigned SEGS = NUM_SEGMENTS
)
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic key_wr_i,
	input wire logic [31:0] key_data_i,
	input wire logic delay_wr_i,
	input wire logic [1:0] delay_data_i,
	output logic [1:0] access_delay_o,
	output logic delay_unlocked_o,
	input wire logic erase_req_i,
	input wire logic [4:0] erase_seg_i,
	output logic erase_busy_o,
	output logic [12:0] flash_addr_o,
	output logic flash_rd_o,
	output logic flash_prog_o,
	output logic flash_erase_o,
	output logic [4:0] flash_seg_o,
	output logic [31:0] flash_wdata_o,
	input wire logic [31:0] flash_rdata_i,
	input wire logic flash_done_i
);
	typedef enum logic [2:0] {ST_IDLE, ST_DEC, ST_WAIT, ST_PROG, ST_ERASE, ST_ERR} state_t;

	// Segment flags are one bit per segment of a five-bit index
	if (SEGS == 0 || SEGS > NUM_SEGMENTS)
	begin : g_bad_segs
		$error("SEGS must lie between 1 and 32");
	end

	logic [1:0] delay_r, delay_nxt;
	logic unlock_r, unlock_nxt;
	state_t state_r, state_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hreadyout_r, hreadyout_nxt;
	logic hresp_r, hresp_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic wr_r, wr_nxt;
	logic oor_r, oor_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic rd_r, rd_nxt;
	logic prog_r, prog_nxt;
	logic erase_r, erase_nxt;
	logic [4:0] eseg_r, eseg_nxt;
	logic [4:0] pseg_r, pseg_nxt;
	logic epend_r, epend_nxt;
	logic qpend_r, qpend_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [SEGS-1:0] blank_r, blank_nxt;
	logic accept;
	logic [1:0] eff_delay;
	logic [4:0] cur_seg;

	// Key and delay update path; a key write arms exactly one delay write
	always_comb
	begin
		delay_nxt = delay_r;
		unlock_nxt = unlock_r;
		if (delay_wr_i)
		begin
			if (unlock_r)
				delay_nxt = delay_data_i;
			unlock_nxt = 1'b0;
		end
		else if (key_wr_i)
			unlock_nxt = (key_data_i == UNLOCK_KEY);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			delay_r <= DELAY_RESET;
			unlock_r <= 1'b0;
		end
		else
		begin
			delay_r <= delay_nxt;
			unlock_r <= unlock_nxt;
		end
	end

	// never shorter than the flash access time
	assign eff_delay = (delay_r < MIN_DELAY) ? MIN_DELAY : delay_r;
	// one slave port behind the bus matrix
	assign accept = hsel_i & htrans_i[HTRANS_ACTIVE_BIT] & hready_i & hreadyout_r
		& ((state_r == ST_IDLE) | (state_r == ST_ERASE));
	assign cur_seg = addr_r[WORD_ADDR_BITS-1 -: SEG_BITS];

	// Transfer sequencer; a queued bus transfer waits out a running erase
	always_comb
	begin
		state_nxt = state_r;
		hrdata_nxt = hrdata_r;
		hreadyout_nxt = hreadyout_r;
		hresp_nxt = hresp_r;
		addr_nxt = addr_r;
		wr_nxt = wr_r;
		oor_nxt = oor_r;
		cnt_nxt = cnt_r;
		rd_nxt = rd_r;
		prog_nxt = prog_r;
		erase_nxt = erase_r;
		eseg_nxt = eseg_r;
		pseg_nxt = pseg_r;
		epend_nxt = epend_r | erase_req_i;
		qpend_nxt = qpend_r;
		wdata_nxt = wdata_r;
		blank_nxt = blank_r;
		// Pending segment kept apart, so a running erase never sees its segment move
		if (erase_req_i && !epend_r)
			pseg_nxt = erase_seg_i;
		if (accept)
		begin
			oor_nxt = (haddr_i - FLASH_BASE) >= 32'(SEGS * SEG_BYTES);
			addr_nxt = haddr_i[FLASH_ADDR_BITS-1:2];
			wr_nxt = hwrite_i;
			hreadyout_nxt = 1'b0;
		end
		case (state_r)
			ST_IDLE:
			begin
				hresp_nxt = 1'b0;
				if (accept)
					state_nxt = ST_DEC;
				else if (epend_r)
				begin
					erase_nxt = 1'b1;
					eseg_nxt = pseg_r;
					epend_nxt = erase_req_i;
					if (erase_req_i)
						pseg_nxt = erase_seg_i;
					state_nxt = ST_ERASE;
				end
			end
			ST_DEC:
			begin
				// write into an unerased segment is refused
				if (oor_r || (wr_r && (32'(cur_seg) >= SEGS || !blank_r[cur_seg])))
				begin
					hresp_nxt = 1'b1;
					state_nxt = ST_ERR;
				end
				else if (wr_r)
				begin
					wdata_nxt = hwdata_i;
					prog_nxt = 1'b1;
					blank_nxt[cur_seg] = 1'b0;
					state_nxt = ST_PROG;
				end
				else
				begin
					cnt_nxt = eff_delay;
					rd_nxt = 1'b1;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (cnt_r == 2'h0)
				begin
					hrdata_nxt = flash_rdata_i;
					rd_nxt = 1'b0;
					hreadyout_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
				else
					cnt_nxt = cnt_r - 2'h1;
			end
			ST_PROG:
			begin
				if (flash_done_i)
				begin
					prog_nxt = 1'b0;
					hreadyout_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_ERASE:
			begin
				if (accept)
					qpend_nxt = 1'b1;
				if (flash_done_i)
				begin
					erase_nxt = 1'b0;
					if (32'(eseg_r) < SEGS)
						blank_nxt[eseg_r] = 1'b1;
					qpend_nxt = 1'b0;
					state_nxt = (qpend_r || accept) ? ST_DEC : ST_IDLE;
				end
			end
			ST_ERR:
			begin
				// First cycle of the two-cycle error answer is on the bus; raise ready for the second
				hreadyout_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
				hreadyout_nxt = 1'b1;
			end
		endcase
	end

	// Sequencer registers; segments start unknown, so treated as not blank
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= ST_IDLE;
			hrdata_r <= 32'h00000000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			addr_r <= 13'h0000;
			wr_r <= 1'b0;
			oor_r <= 1'b0;
			cnt_r <= 2'h0;
			rd_r <= 1'b0;
			prog_r <= 1'b0;
			erase_r <= 1'b0;
			eseg_r <= 5'h00;
			pseg_r <= 5'h00;
			epend_r <= 1'b0;
			qpend_r <= 1'b0;
			wdata_r <= 32'h00000000;
			blank_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			hrdata_r <= hrdata_nxt;
			hreadyout_r <= hreadyout_nxt;
			hresp_r <= hresp_nxt;
			addr_r <= addr_nxt;
			wr_r <= wr_nxt;
			oor_r <= oor_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			prog_r <= prog_nxt;
			erase_r <= erase_nxt;
			eseg_r <= eseg_nxt;
			pseg_r <= pseg_nxt;
			epend_r <= epend_nxt;
			qpend_r <= qpend_nxt;
			wdata_r <= wdata_nxt;
			blank_r <= blank_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign hrdata_o = hrdata_r;
	assign hreadyout_o = hreadyout_r;
	assign hresp_o = hresp_r;
	assign access_delay_o = delay_r;
	assign delay_unlocked_o = unlock_r;
	assign erase_busy_o = erase_r;
	assign flash_addr_o = addr_r;
	assign flash_rd_o = rd_r;
	assign flash_prog_o = prog_r;
	assign flash_erase_o = erase_r;
	assign flash_seg_o = eseg_r;
	assign flash_wdata_o = wdata_r;

	// Helper: read strobe length and first cycle after reset
	logic [2:0] rd_len_r;
	logic [1:0] rd_lat_r;
	logic post_rst_r;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_len_r <= 3'h0;
			rd_lat_r <= 2'h0;
			post_rst_r <= 1'b0;
		end
		else
		begin
			rd_len_r <= rd_r ? rd_len_r + 3'h1 : 3'h0;
			rd_lat_r <= (state_r == ST_DEC) ? eff_delay : rd_lat_r;
			post_rst_r <= 1'b1;
		end
	end

	sequence s_read_issue;
		state_r == ST_DEC && !wr_r && !oor_r;
	endsequence
	sequence s_bad_access;
		state_r == ST_DEC && oor_r;
	endsequence

	property p_read_len;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(rd_r) |-> rd_len_r == 3'(rd_lat_r) + 3'h1;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read strobe length wrong");
	property p_reset_delay;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!post_rst_r |-> delay_r == DELAY_RESET;
	endproperty
	a_reset_delay: assert property (p_reset_delay) else $error("delay not three after reset");
	property p_min_access;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(rd_r) |-> rd_len_r >= 3'(MIN_DELAY) + 3'h1;
	endproperty
	a_min_access: assert property (p_min_access) else $error("flash access too short");
	property p_keyed_update;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_wr_i && key_data_i == UNLOCK_KEY && !delay_wr_i ##1 delay_wr_i
			|=> delay_r == $past(delay_data_i);
	endproperty
	a_keyed_update: assert property (p_keyed_update) else $error("keyed delay write lost");
	property p_locked_ignore;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		delay_wr_i && !unlock_r |=> $stable(delay_r);
	endproperty
	a_locked_ignore: assert property (p_locked_ignore) else $error("locked delay write taken");
	property p_read_done;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_read_issue |-> ##[2:5] (hreadyout_r && !hresp_r);
	endproperty
	a_read_done: assert property (p_read_done) else $error("read not answered in time");
	property p_out_of_map;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_bad_access |=> hresp_r && !hreadyout_r ##1 hresp_r && hreadyout_r;
	endproperty
	a_out_of_map: assert property (p_out_of_map) else $error("bad address not errored");
	property p_prog_stall;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		prog_r |-> !hreadyout_r;
	endproperty
	a_prog_stall: assert property (p_prog_stall) else $error("bus released during program");
	property p_erase_seg;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		erase_r && $past(erase_r) |-> $stable(eseg_r);
	endproperty
	a_erase_seg: assert property (p_erase_seg) else $error("erase segment moved");
endmodule
`default_nettype wire

//--- flash_ctrl_pkg.sv
/*
 * Shared constants for the flash access controller: array geometry, the
 * unlock key, access delay reset value and flash timing figures.
 * Assumes a single system clock at SYS_CLK_HZ driving all of the logic.
 */
package flash_ctrl_pkg;
	// Array geometry
	localparam int unsigned SEG_BYTES = 1024;
	localparam int unsigned NUM_SEGMENTS = 32;
	localparam int unsigned SEG_BITS = 5;
	localparam int unsigned FLASH_ADDR_BITS = 15;
	localparam int unsigned WORD_ADDR_BITS = 13;
	localparam logic [31:0] FLASH_BASE = 32'h00000000;
	// Unlock key and access delay setting
	localparam logic [31:0] UNLOCK_KEY = 32'h12345678;
	localparam int unsigned DELAY_BITS = 2;
	localparam logic [1:0] DELAY_RESET = 2'h3;
	localparam logic [1:0] DELAY_MAX = 2'h3;
	// Flash timing: access time in ns and system clock
	localparam int unsigned FLASH_ACCESS_NS = 40;
	localparam int unsigned SYS_CLK_HZ = 10000000;
	localparam int unsigned SYS_CLK_NS = 1000000000 / SYS_CLK_HZ;
	// Least cycles per flash access, rounded up, never below one
	localparam int unsigned ACCESS_CYCLES_RAW = (FLASH_ACCESS_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int unsigned ACCESS_CYCLES = (ACCESS_CYCLES_RAW < 1) ? 1 : ACCESS_CYCLES_RAW;
	localparam logic [1:0] MIN_DELAY = 2'(ACCESS_CYCLES - 1);
	// Bus transfer type bit that marks an active transfer
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;
	localparam logic [1:0] SEG_LOW_ZERO = 2'h0;
endpackage

//--- flash_macro_model.sv
/*
 * Behavioural flash macro for the bench: 8192 words, program ANDs bits,
 * segment erase sets words to all ones, done pulse after DONE_LAT cycles.
 * Assumes strobes from the controller on the same rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_macro_model
#(
	parameter int DONE_LAT = 6
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [12:0] addr_i,
	input wire logic rd_i,
	input wire logic prog_i,
	input wire logic erase_i,
	input wire logic [4:0] seg_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o,
	output logic done_o
);
	logic [31:0] mem [0:8191];
	logic [31:0] last_r;
	int cnt;
	initial
	begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 32'h5A5A0000 ^ 32'(i);
	end
	// Idle read bus toggles so a stale sample never looks right
	assign rdata_o = rd_i ? mem[addr_i] : ~last_r;
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt <= 0;
			done_o <= 1'b0;
			last_r <= 32'h0;
		end
		else
		begin
			last_r <= rdata_o;
			done_o <= 1'b0;
			if ((prog_i || erase_i) && !done_o)
			begin
				cnt <= cnt + 1;
				if (cnt == DONE_LAT - 1)
				begin
					cnt <= 0;
					done_o <= 1'b1;
					if (prog_i)
						mem[addr_i] <= mem[addr_i] & wdata_i;
					else
						for (int i = 0; i < 256; i++)
							mem[{seg_i, 8'(i)}] <= 32'hFFFFFFFF;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- flash_wait_state_access_ctrl_tb.sv
/*
 * Self-checking bench for the flash access controller with a flash macro
 * model. Assumes the package constants and a 10 MHz system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_wait_state_access_ctrl_tb;
	import flash_ctrl_pkg::*;
	localparam int LAT = 6;
	logic ref_clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, hready_i;
	logic key_wr_i = 0, delay_wr_i = 0, erase_req_i = 0, flash_done_i;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, key_data_i = 32'h0;
	logic [1:0] htrans_i = 2'h0, delay_data_i = 2'h0, access_delay_o;
	logic [4:0] erase_seg_i = 5'h0, flash_seg_o;
	logic [31:0] hrdata_o, flash_wdata_o, flash_rdata_i;
	logic hreadyout_o, hresp_o, delay_unlocked_o, erase_busy_o;
	logic flash_rd_o, flash_prog_o, flash_erase_o;
	logic [12:0] flash_addr_o;
	int err_total = 0, tests_run = 0, cyc_cnt = 0;
	logic [31:0] exp_mem [int];
	bit blank [32];
	logic [1:0] exp_ws = 2'h3;
	logic [31:0] a;
	logic [31:0] q_rd;
	logic q_er;
	int q_n;
	// Bus ready loops back as on a single-slave bus
	assign hready_i = hreadyout_o;
	always #50 ref_clk_i = ~ref_clk_i;
	flash_wait_state_access_ctrl i_dut (.ref_clk_i, .rst_n_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
		.key_wr_i, .key_data_i, .delay_wr_i, .delay_data_i, .access_delay_o,
		.delay_unlocked_o, .erase_req_i, .erase_seg_i, .erase_busy_o, .flash_addr_o,
		.flash_rd_o, .flash_prog_o, .flash_erase_o, .flash_seg_o, .flash_wdata_o,
		.flash_rdata_i, .flash_done_i);
	flash_macro_model #(.DONE_LAT(LAT)) i_flash (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.addr_i(flash_addr_o), .rd_i(flash_rd_o), .prog_i(flash_prog_o),
		.erase_i(flash_erase_o), .seg_i(flash_seg_o), .wdata_i(flash_wdata_o),
		.rdata_o(flash_rdata_i), .done_o(flash_done_i));
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Expected flash word: written value or the model's fill pattern
	function automatic logic [31:0] word_of(input logic [31:0] ad);
		int w;
		w = int'(ad[14:2]);
		return exp_mem.exists(w) ? exp_mem[w] : 32'h5A5A0000 ^ 32'(w);
	endfunction
	// One bus transfer; n counts cycles from the take edge to ready
	task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d,
		output logic [31:0] rd, output logic er, output int n);
		@(negedge ref_clk_i);
		hsel_i = 1'b1;
		htrans_i = 2'h2;
		haddr_i = ad;
		hwrite_i = w;
		@(negedge ref_clk_i);
		hsel_i = 1'b0;
		htrans_i = 2'h0;
		hwdata_i = d;
		n = 0;
		while (hreadyout_o !== 1'b1 && n < 400)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		rd = hrdata_o;
		er = hresp_o;
	endtask
	task automatic do_rd(input logic [31:0] ad);
		logic [31:0] rd;
		logic er;
		int n;
		xfer(1'b0, ad, 32'h0, rd, er, n);
		chk({31'h0, er}, {31'h0, ad >= 32'h8000}, "read response");
		if (ad < 32'h8000)
		begin
			chk(rd, word_of(ad), "read data");
			chk(n, 32'(exp_ws) + 2, "read cycles");
		end
	endtask
	task automatic do_wr(input logic [31:0] ad, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		int n;
		bit ok;
		ok = ad < 32'h8000 && blank[ad[14:10]];
		xfer(1'b1, ad, d, rd, er, n);
		chk({31'h0, er}, {31'h0, !ok}, "write response");
		if (ok)
		begin
			chk({31'h0, n > LAT}, 32'h1, "write stall");
			exp_mem[int'(ad[14:2])] = d;
			blank[ad[14:10]] = 0;
		end
	endtask
	task automatic do_erase(input logic [4:0] s);
		int n;
		@(negedge ref_clk_i);
		erase_req_i = 1'b1;
		erase_seg_i = s;
		@(negedge ref_clk_i);
		erase_req_i = 1'b0;
		for (n = 0; n < 10 && erase_busy_o !== 1'b1; n++)
			@(negedge ref_clk_i);
		chk({27'h0, flash_seg_o}, {27'h0, s}, "erase segment");
		for (n = 0; n < 50 && erase_busy_o !== 1'b0; n++)
			@(negedge ref_clk_i);
		chk({31'h0, erase_busy_o}, 32'h0, "erase end");
		blank[s] = 1;
		for (int i = 0; i < 256; i++)
			exp_mem[int'({s, 8'(i)})] = 32'hFFFFFFFF;
	endtask
	task automatic set_delay(input logic [31:0] k, input logic [1:0] v);
		@(negedge ref_clk_i);
		key_wr_i = 1'b1;
		key_data_i = k;
		@(negedge ref_clk_i);
		key_wr_i = 1'b0;
		chk({31'h0, delay_unlocked_o}, {31'h0, k == UNLOCK_KEY}, "unlock");
		delay_wr_i = 1'b1;
		delay_data_i = v;
		@(negedge ref_clk_i);
		delay_wr_i = 1'b0;
		if (k == UNLOCK_KEY)
			exp_ws = v;
		chk({30'h0, access_delay_o}, {30'h0, exp_ws}, "delay");
	endtask
	// Hang guard: the whole run needs under two hundred cycles
	always @(posedge ref_clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			err_total++;
			$display("unexpected at %0t: run limit reached", $time);
			summarize();
		end
	end
	initial
	begin
		void'($urandom(65334));
		repeat (2) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		chk({30'h0, access_delay_o}, 32'h3, "reset delay");
		do_rd(32'h0);
		$display("test reset done");
		// bench clock stays at 10 MHz, so every delay 0..3 is legal
		for (int v = 0; v < 4; v++)
		begin
			set_delay(UNLOCK_KEY, 2'(v));
			do_rd($urandom % 32'h8000);
		end
		set_delay(UNLOCK_KEY ^ (32'h1 << ($urandom % 32)), 2'h1);
		do_rd(32'h7FFC);
		do_rd(32'h8000);
		$display("test delay done");
		a = {17'h0, 5'($urandom), 8'($urandom), 2'h0};
		do_wr(a, $urandom);
		do_erase(a[14:10]);
		do_wr(a, $urandom);
		do_rd(a);
		do_rd((a + 32'h400) % 32'h8000);
		do_wr(a ^ 32'h4, $urandom);
		do_rd(a ^ 32'h4);
		// no instruction stream; one data read waits out a running erase
		@(negedge ref_clk_i);
		erase_req_i = 1'b1;
		erase_seg_i = a[14:10] ^ 5'h1;
		@(negedge ref_clk_i);
		erase_req_i = 1'b0;
		blank[a[14:10] ^ 5'h1] = 1;
		for (int i = 0; i < 256; i++)
			exp_mem[int'({a[14:10] ^ 5'h1, 8'(i)})] = 32'hFFFFFFFF;
		xfer(1'b0, a, 32'h0, q_rd, q_er, q_n);
		chk(q_rd, word_of(a), "queued read data");
		chk({31'h0, q_n > LAT}, 32'h1, "queued read wait");
		chk({31'h0, q_er}, 32'h0, "queued read response");
		$display("test program done");
		repeat (6) do_rd($urandom % 32'h8000);
		$display("test random done");
		summarize();
	end
endmodule
`default_nettype wire
